// ### asrc_pkg.sv
package asrc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // write cycle figures (ns)
  localparam int T_AS_NS = 0;
  localparam int T_WP_NS = 65;
  localparam int T_WR_NS = 0;
  localparam int T_DW_NS = 35;
  localparam int T_DH_NS = 0;
  localparam int T_WHZ_NS = 30;
  // read cycle figures (ns)
  localparam int T_AA_NS = 85;
  localparam int T_HZ_NS = 30;
  localparam int T_CDR_NS = 0;
  // least times round up to whole cycles
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AA_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHZ_CYC = (T_WHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  typedef enum logic [1:0] {ASRC_OP_READ, ASRC_OP_WRITE, ASRC_OP_RETAIN} asrc_op_t;
endpackage

// ### asrc_pins_if.sv
`timescale 1ns/100ps
interface asrc_pins_if;
  import asrc_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic sel_low_n;
  logic sel_high;
  logic write_n;
  logic [DATA_W-1:0] dout;
  logic dout_en;
  modport ctrl (output addr, sel_low_n, sel_high, write_n, dout, dout_en);
  modport pins (input addr, sel_low_n, sel_high, write_n, dout, dout_en);
endinterface

// ### asrc_sync.sv
`timescale 1ns/100ps
module asrc_sync
  import asrc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins
  input wire logic [DATA_W-1:0] async_in,
  output logic [DATA_W-1:0] sync_out
);
  logic [DATA_W-1:0] s1_q;
  logic [DATA_W-1:0] s1_d;
  logic [DATA_W-1:0] s2_q;
  logic [DATA_W-1:0] s2_d;
  always_comb begin
    s1_d = rst_n ? async_in : 8'h00;
    s2_d = rst_n ? s1_q : 8'h00;
  end
  always_ff @(posedge sys_clk) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
  end
  assign sync_out = s2_q;
endmodule

// ### asrc_ctrl.sv
// What this block does
// - address moves only with access strobes idle
// - drive bus only after memory releases it
// - retention by low select holds high select rail
// - retention by high select held low
// - deselect no later than retention start
// - strobe stays high through read cycle
`timescale 1ns/100ps
module asrc_ctrl
  import asrc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request
  input wire logic req_valid,
  input wire asrc_op_t req_op,
  input wire logic retain_by_high,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic retaining,
  // memory pins
  output logic [ADDR_W-1:0] word_address_lines,
  output logic select_low_active_n,
  output logic select_high_active,
  output logic write_strobe_n,
  output logic [DATA_W-1:0] byte_bus_pins_o,
  output logic byte_bus_pins_oe,
  input wire logic [DATA_W-1:0] byte_bus_pins_i
);
  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_RD, ASRC_RD_OFF, ASRC_WR_SET, ASRC_WR_PULSE, ASRC_RETAIN
  } asrc_state_t;

  // pin group kept in one bundle so the pad side sees it whole
  asrc_pins_if pins ();
  logic [DATA_W-1:0] bus_sync;
  asrc_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d;
  logic sel_n_q, sel_n_d;
  logic sel_h_q, sel_h_d;
  logic we_n_q, we_n_d;
  logic oe_q, oe_d;
  logic ready_q, ready_d;
  logic rdv_q, rdv_d;
  logic ret_q, ret_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;

  // read data is sampled through two flops; data from the pins is not on our clock
  asrc_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(byte_bus_pins_i),
    .sync_out(bus_sync)
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    sel_n_d = sel_n_q;
    sel_h_d = sel_h_q;
    we_n_d = we_n_q;
    oe_d = oe_q;
    // ready is low in every state but idle
    ready_d = 1'b0;
    rdv_d = 1'b0;
    rdat_d = rdat_q;
    ret_d = ret_q;
    unique case (state_q)
      ASRC_IDLE: begin
        ready_d = 1'b1;
        // a request is taken only once ready has been shown for a cycle
        if (req_valid && ready_q) begin
          ready_d = 1'b0;
          // address changes here while all strobes are idle
          addr_d = req_addr;
          wdat_d = req_wdata;
          cnt_d = CNT_RESET;
          unique case (req_op)
            ASRC_OP_READ: begin
              sel_n_d = 1'b0;
              sel_h_d = 1'b1;
              we_n_d = 1'b1;
              state_d = ASRC_RD;
            end
            ASRC_OP_WRITE: begin
              // selects go active first: the memory may start driving a read,
              // so our data waits until the strobe has forced it off
              sel_n_d = 1'b0;
              sel_h_d = 1'b1;
              state_d = ASRC_WR_SET;
            end
            default: begin
              // deselect in the same edge retention begins
              sel_n_d = 1'b1;
              sel_h_d = retain_by_high ? 1'b0 : 1'b1;
              we_n_d = 1'b1;
              ret_d = 1'b1;
              state_d = ASRC_RETAIN;
            end
          endcase
        end
      end
      ASRC_RD: begin
        cnt_d = cnt_q + 4'h1;
        // two extra cycles cover the input synchroniser
        if (cnt_q == 4'(AA_CYC + 2)) begin
          // selects drop with the capture so the memory lets go early
          rdat_d = bus_sync;
          rdv_d = 1'b1;
          sel_n_d = 1'b1;
          sel_h_d = 1'b0;
          cnt_d = CNT_RESET;
          state_d = ASRC_RD_OFF;
        end
      end
      ASRC_RD_OFF: begin
        cnt_d = cnt_q + 4'h1;
        // wait for the memory to release before anyone may drive
        if (cnt_q == 4'(HZ_CYC)) begin
          state_d = ASRC_IDLE;
        end
      end
      ASRC_WR_SET: begin
        // strobe falls after the selects; the memory goes off the bus
        we_n_d = 1'b0;
        cnt_d = CNT_RESET;
        state_d = ASRC_WR_PULSE;
      end
      ASRC_WR_PULSE: begin
        cnt_d = cnt_q + 4'h1;
        // drive starts only once the memory has surely let go of the bus
        if (cnt_q == 4'(WHZ_CYC)) begin
          oe_d = 1'b1;
        end
        if (cnt_q == 4'(WHZ_CYC + WP_CYC)) begin
          // strobe ends the write; data and address held through that edge
          we_n_d = 1'b1;
          state_d = ASRC_RD_OFF;
          cnt_d = CNT_RESET;
          sel_n_d = 1'b1;
          sel_h_d = 1'b0;
        end
      end
      ASRC_RETAIN: begin
        // any other request wakes the memory; it is consumed, not executed
        // the high select leaves its rail only as retention ends
        if (req_valid && req_op != ASRC_OP_RETAIN) begin
          ret_d = 1'b0;
          sel_h_d = 1'b0;
          state_d = ASRC_IDLE;
        end
      end
      default: state_d = ASRC_IDLE;
    endcase
    // drive stops one edge after the strobe rises, so data hold is met
    if (state_q == ASRC_RD_OFF) begin
      oe_d = 1'b0;
    end
    // synchronous reset overrides every next value
    if (!rst_n) begin
      state_d = ASRC_IDLE;
      cnt_d = CNT_RESET;
      addr_d = '0;
      wdat_d = 8'h00;
      sel_n_d = 1'b1;
      sel_h_d = 1'b0;
      we_n_d = 1'b1;
      oe_d = 1'b0;
      ready_d = 1'b0;
      rdv_d = 1'b0;
      rdat_d = 8'h00;
      ret_d = 1'b0;
    end
  end

  // every pin comes from a flop, so no glitch reaches the memory
  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
    cnt_q <= cnt_d;
    addr_q <= addr_d;
    wdat_q <= wdat_d;
    sel_n_q <= sel_n_d;
    sel_h_q <= sel_h_d;
    we_n_q <= we_n_d;
    oe_q <= oe_d;
    ready_q <= ready_d;
    rdv_q <= rdv_d;
    rdat_q <= rdat_d;
    ret_q <= ret_d;
  end

  assign pins.addr = addr_q;
  assign pins.sel_low_n = sel_n_q;
  assign pins.sel_high = sel_h_q;
  assign pins.write_n = we_n_q;
  assign pins.dout = wdat_q;
  assign pins.dout_en = oe_q;

  // pins leave through the bundle so they stay one group
  assign word_address_lines = pins.addr;
  assign select_low_active_n = pins.sel_low_n;
  assign select_high_active = pins.sel_high;
  assign write_strobe_n = pins.write_n;
  assign byte_bus_pins_o = pins.dout;
  assign byte_bus_pins_oe = pins.dout_en;
  assign req_ready = ready_q;
  assign rd_valid = rdv_q;
  assign rd_data = rdat_q;
  assign retaining = ret_q;
endmodule

// ### asrc_sram_model.sv
`timescale 1ns/100ps
module asrc_sram_model
  import asrc_pkg::*;
(
  // pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic sel_low_n,
  input wire logic sel_high,
  input wire logic write_n,
  input wire logic [DATA_W-1:0] din,
  // read side
  output logic [DATA_W-1:0] q,
  output logic drv
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic sel;
  assign sel = !sel_low_n && sel_high;
  // strobe low releases the pins, so a late select never drives
  assign drv = sel && write_n;
  assign q = mem[addr];
  // level write: the last byte on the bus before the overlap ends is kept
  always @* if (sel && !write_n) mem[addr] = din;
endmodule

// ### asrc_checker.sv
`timescale 1ns/100ps
module asrc_checker
  import asrc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request side
  input wire logic req_valid,
  input wire asrc_op_t req_op,
  input wire logic retain_by_high,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic retaining,
  // memory pins
  input wire logic [ADDR_W-1:0] word_address_lines,
  input wire logic select_low_active_n,
  input wire logic select_high_active,
  input wire logic write_strobe_n,
  input wire logic [DATA_W-1:0] byte_bus_pins_o,
  input wire logic byte_bus_pins_oe,
  input wire logic [DATA_W-1:0] byte_bus_pins_i
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic idle, mem_out;
  assign idle = select_low_active_n || !select_high_active || write_strobe_n;
  assign mem_out = !select_low_active_n && select_high_active && write_strobe_n;
  a_addr_idle: assert property (!$stable(word_address_lines) |-> idle && $past(idle))
    else $error("address moved in access");
  a_bus_contend: assert property (!(byte_bus_pins_oe && mem_out))
    else $error("bus contention");
  a_read_strobe: assert property (rd_valid |-> $past(write_strobe_n) && $past(write_strobe_n, 6)
    && $past(write_strobe_n, 11)) else $error("strobe low in read");
  a_sel_first: assert property ($fell(write_strobe_n) |->
    $past(!select_low_active_n && select_high_active)) else $error("late select");
  a_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*7])
    else $error("short write pulse");
  a_data_setup: assert property ($rose(write_strobe_n) |-> byte_bus_pins_oe
    && $past(byte_bus_pins_oe, 4) && $stable(byte_bus_pins_o)) else $error("data setup");
  a_retain_desel: assert property ($rose(retaining) |-> !mem_out && write_strobe_n)
    else $error("not deselected");
  a_retain_pins: assert property (retaining && $past(retaining) |-> select_low_active_n
    && $stable(select_high_active)) else $error("retention pins moved");
  a_rd_latency: assert property (req_valid && req_ready && req_op == ASRC_OP_READ |->
    ##13 rd_valid) else $error("read latency");
  a_rd_pulse: assert property (rd_valid |=> !rd_valid) else $error("long read pulse");
  cover property ($rose(retaining) && retain_by_high);
  cover property ($rose(retaining) && !retain_by_high);
  cover property ($fell(write_strobe_n));
  cover property (rd_valid);
endmodule

// ### tb.sv
`timescale 1ns/100ps
bind asrc_ctrl asrc_checker i_asrc_checker (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .req_valid(req_valid),
  .req_op(req_op),
  .retain_by_high(retain_by_high),
  .req_addr(req_addr),
  .req_wdata(req_wdata),
  .req_ready(req_ready),
  .rd_valid(rd_valid),
  .rd_data(rd_data),
  .retaining(retaining),
  .word_address_lines(word_address_lines),
  .select_low_active_n(select_low_active_n),
  .select_high_active(select_high_active),
  .write_strobe_n(write_strobe_n),
  .byte_bus_pins_o(byte_bus_pins_o),
  .byte_bus_pins_oe(byte_bus_pins_oe),
  .byte_bus_pins_i(byte_bus_pins_i)
);
module tb;
  import asrc_pkg::*;
  logic sys_clk = 0, rst_n = 0, req_valid = 0, retain_by_high = 0;
  asrc_op_t req_op = ASRC_OP_READ;
  logic [ADDR_W-1:0] req_addr = '0, word_address_lines;
  logic [DATA_W-1:0] req_wdata = '0, rd_data, byte_bus_pins_o, byte_bus_pins_i, bus_q = '0, mq;
  logic req_ready, rd_valid, retaining, select_low_active_n, select_high_active;
  logic write_strobe_n, byte_bus_pins_oe, mdrv;
  int err_count = 0, n_compared = 0, cyc = 0;
  asrc_ctrl i_asrc_ctrl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req_op(req_op),
    .retain_by_high(retain_by_high),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_ready(req_ready),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .retaining(retaining),
    .word_address_lines(word_address_lines),
    .select_low_active_n(select_low_active_n),
    .select_high_active(select_high_active),
    .write_strobe_n(write_strobe_n),
    .byte_bus_pins_o(byte_bus_pins_o),
    .byte_bus_pins_oe(byte_bus_pins_oe),
    .byte_bus_pins_i(byte_bus_pins_i)
  );
  asrc_sram_model i_asrc_sram_model (.addr(word_address_lines), .sel_low_n(select_low_active_n),
    .sel_high(select_high_active), .write_n(write_strobe_n), .din(byte_bus_pins_i),
    .q(mq), .drv(mdrv));
  // an undriven bus flips each cycle so a stale byte never reads back right
  assign byte_bus_pins_i = byte_bus_pins_oe ? byte_bus_pins_o : (mdrv ? mq : ~bus_q);
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    bus_q <= byte_bus_pins_i;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [DATA_W-1:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic req(input asrc_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk) #1 n++;
    end
    chk(req_ready, 1'b1);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1;
    @(posedge sys_clk) #1 req_valid = 0;
    @(posedge sys_clk) #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int n;
    n = 0;
    req(ASRC_OP_READ, a, 8'h00);
    while (rd_valid !== 1'b1 && n < 20) begin
      @(posedge sys_clk) #1 n++;
    end
    chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask
  task automatic t_write_read();
    req(ASRC_OP_WRITE, 15'h0000, 8'h5A);
    req(ASRC_OP_WRITE, 15'h7FFF, 8'hC3);
    req(ASRC_OP_WRITE, 15'h0000, 8'h96);
    rd(15'h7FFF, 8'hC3);
    rd(15'h0000, 8'h96);
    $display("write_read done");
  endtask
  task automatic t_retain(input logic m);
    int n;
    n = 0;
    retain_by_high = m;
    req(ASRC_OP_RETAIN, 15'h0000, 8'h00);
    chk({retaining, select_low_active_n, select_high_active}, {2'b11, !m});
    req_op = ASRC_OP_READ;
    req_valid = 1;
    @(posedge sys_clk) #1 req_valid = 0;
    while (retaining !== 1'b0 && n < 20) begin
      @(posedge sys_clk) #1 n++;
    end
    chk(retaining, 1'b0);
    rd(15'h0000, 8'h96);
    $display("retain done");
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1;
    t_write_read();
    t_retain(1'b0);
    t_retain(1'b1);
    final_report();
  end
endmodule
